//--- inc/bert_pkg.sv
// Constants shared by the pattern test control block and its shift register.
// Assumes one 200 MHz clock and an 8-bit register port.
package bert_pkg;

	// Register port widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register indices
	localparam logic [7:0] OFS_PATTERN_TEST_CONTROL_STATUS = 8'h00;
	localparam logic [7:0] OFS_LOOP_CODE_CONTROL_RESERVED = 8'h01;
	localparam logic [7:0] OFS_TX_LOOP_CODE_RESERVED = 8'h02;
	localparam logic [7:0] OFS_PATH_SWAP = 8'h03;
	localparam logic [7:0] OFS_INT_STATUS = 8'h04;
	localparam logic [7:0] OFS_INT_CLEAR = 8'h05;
	localparam logic [7:0] OFS_INT_ENABLE = 8'h06;

	// Control and status field positions
	localparam int BIT_TX_FRAMER_SKIP = 0;
	localparam int BIT_RX_FRAMER_SKIP = 1;
	localparam int BIT_GENERATOR_ENABLE = 2;
	localparam int BIT_CHECKER_ENABLE = 3;
	localparam int BIT_CHECKER_LOCK_STATUS = 4;
	localparam int BIT_DATA_INVERT = 5;
	localparam int BIT_SINGLE_ERROR_INJECT = 6;
	localparam int BIT_PATTERN_TYPE_SELECT = 7;
	localparam int BIT_PATH_SWAP = 0;

	// Interrupt status layout
	localparam int INT_W = 3;
	localparam int INT_LOCK_GAINED = 0;
	localparam int INT_LOCK_LOST = 1;
	localparam int INT_BIT_ERROR = 2;

	// Reset values
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [INT_W-1:0] INT_RESET = 3'h0;

	// Pattern shift register geometry
	localparam int LFSR_W = 20;
	localparam int PRBS15_LEN = 15;
	localparam int PRBS15_TAP = 14;
	localparam int QRTS_LEN = 20;
	localparam int QRTS_TAP = 17;
	localparam int QRTS_ZERO_RUN = 14;

	// Timing
	localparam longint CLK_HZ = 200000000;
	localparam longint BIT_RATE_HZ = 2048000;
	localparam int BIT_DIV = int'(CLK_HZ / BIT_RATE_HZ);
	localparam int LOCK_MATCHES = 32;
	localparam int LOSS_WINDOW = 64;
	localparam int LOSS_ERRORS = 6;

endpackage

//--- logic/bert_ctl.sv
// Pattern test generator and checker control with framer bypass enables.
// Assumes serial pins from the line and backplane are asynchronous to clk.
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
module bert_ctl
#(
	parameter int BIT_DIV_P = bert_pkg::BIT_DIV,
	parameter int LOCK_MATCHES_P = bert_pkg::LOCK_MATCHES,
	parameter int LOSS_WINDOW_P = bert_pkg::LOSS_WINDOW,
	parameter int LOSS_ERRORS_P = bert_pkg::LOSS_ERRORS
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register port
	input wire logic [bert_pkg::ADDR_W-1:0] addr,
	input wire logic [bert_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [bert_pkg::DATA_W-1:0] rdata,
	// Interrupt
	output logic irq,
	// Line receive pins
	input wire logic line_rx_bit,
	input wire logic line_rx_strobe,
	// Transmit backplane pins
	input wire logic bp_tx_bit,
	input wire logic bp_tx_strobe,
	// Line transmit
	output logic line_tx_bit,
	output logic line_tx_strobe,
	// Receive backplane
	output logic bp_rx_bit,
	output logic bp_rx_strobe,
	// Framer bypass levels
	output logic rx_framer_skip,
	output logic tx_framer_skip
);
	import bert_pkg::*;

	localparam int DIV_W = $clog2(BIT_DIV_P + 1);
	localparam int CNT_W = $clog2(LOSS_WINDOW_P + LOCK_MATCHES_P + 1);

	logic [7:0] ctl_q, ctl_view;
	logic [INT_W-1:0] int_st_q, int_en_q, int_ev;
	logic [DATA_W-1:0] rdata_q;
	logic [3:0] meta_q, sync_q;
	logic [1:0] strobe_prev_q;
	logic [DIV_W-1:0] div_q;
	logic [CNT_W-1:0] match_q, win_q, errs_q;
	logic swap_q, irq_q, err_pend_q, lock_q;
	logic line_tx_bit_q, line_tx_strobe_q, bp_rx_bit_q, bp_rx_strobe_q;
	logic ctl_wr, tick, gen_en, chk_en, qrts, inv;
	logic line_rx_step, bp_tx_step, gen_bit, gen_step, err_rise;
	logic chk_src_bit, chk_src_step, chk_in, chk_pred, chk_step, chk_err;
	assign ctl_wr = wr && (addr == OFS_PATTERN_TEST_CONTROL_STATUS);
	assign gen_en = ctl_q[BIT_GENERATOR_ENABLE];
	assign chk_en = ctl_q[BIT_CHECKER_ENABLE];
	assign qrts = ctl_q[BIT_PATTERN_TYPE_SELECT];
	assign inv = ctl_q[BIT_DATA_INVERT];

	// Control register; lock bit position is never stored here
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ctl_q <= CTL_RESET;
		else if (ctl_wr)
			ctl_q <= wdata & ~(8'h01 << BIT_CHECKER_LOCK_STATUS);
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			swap_q <= 1'b0;
		else if (wr && (addr == OFS_PATH_SWAP))
			swap_q <= wdata[BIT_PATH_SWAP];
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			int_en_q <= INT_RESET;
		else if (wr && (addr == OFS_INT_ENABLE))
			int_en_q <= wdata[INT_W-1:0];
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			int_st_q <= INT_RESET;
		else if (wr && (addr == OFS_INT_CLEAR))
			int_st_q <= (int_st_q & ~wdata[INT_W-1:0]) | int_ev;
		else
			int_st_q <= int_st_q | int_ev;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			irq_q <= 1'b0;
		else
			irq_q <= |(int_st_q & int_en_q);
	end

	// lock in bit 4; a disabled checker never shows lock
	assign ctl_view = ctl_q | (8'(lock_q && chk_en) << BIT_CHECKER_LOCK_STATUS);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rdata_q <= '0;
		else if (!rd)
			rdata_q <= '0;
		else
			case (addr)
				OFS_PATTERN_TEST_CONTROL_STATUS: rdata_q <= ctl_view;
				OFS_PATH_SWAP: rdata_q <= {7'h00, swap_q};
				OFS_INT_STATUS: rdata_q <= {5'h00, int_st_q};
				OFS_INT_ENABLE: rdata_q <= {5'h00, int_en_q};
				default: rdata_q <= '0;
			endcase
	end

	// Pins cross into clk through two flops
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_q <= '0;
			sync_q <= '0;
			strobe_prev_q <= '0;
		end
		else
		begin
			meta_q <= {bp_tx_strobe, bp_tx_bit, line_rx_strobe, line_rx_bit};
			sync_q <= meta_q;
			strobe_prev_q <= {sync_q[3], sync_q[1]};
		end
	end

	assign line_rx_step = sync_q[1] && !strobe_prev_q[0];
	assign bp_tx_step = sync_q[3] && !strobe_prev_q[1];

	// Generator bit rate; divider rounds down so it runs slightly fast
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			div_q <= '0;
		else if (div_q == DIV_W'(BIT_DIV_P - 1))
			div_q <= '0;
		else
			div_q <= div_q + DIV_W'(1);
	end

	assign tick = (div_q == DIV_W'(BIT_DIV_P - 1));
	assign gen_step = gen_en && tick;

	pattern_lfsr u_gen
	(
		.clk(clk),
		.rst_b(rst_b),
		.step(gen_step),
		.qrts(qrts),
		.self_sync(1'b0),
		.rx_bit(1'b0),
		.out_bit(gen_bit)
	);

	assign err_rise = ctl_wr && wdata[BIT_SINGLE_ERROR_INJECT]
		&& !ctl_q[BIT_SINGLE_ERROR_INJECT] && gen_en;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			err_pend_q <= 1'b0;
		else if (err_rise)
			err_pend_q <= 1'b1;
		else if (gen_step || !gen_en)
			err_pend_q <= 1'b0;
	end

	// pattern toward line when not swapped
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			line_tx_bit_q <= 1'b0;
			line_tx_strobe_q <= 1'b0;
		end
		else if (gen_en && !swap_q)
		begin
			line_tx_strobe_q <= gen_step;
			if (gen_step)
				line_tx_bit_q <= gen_bit ^ inv ^ err_pend_q;
		end
		else
		begin
			line_tx_strobe_q <= bp_tx_step;
			if (bp_tx_step)
				line_tx_bit_q <= sync_q[2];
		end
	end

	// pattern to receive backplane when swapped
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bp_rx_bit_q <= 1'b0;
			bp_rx_strobe_q <= 1'b0;
		end
		else if (gen_en && swap_q)
		begin
			bp_rx_strobe_q <= gen_step;
			if (gen_step)
				bp_rx_bit_q <= gen_bit ^ inv ^ err_pend_q;
		end
		else
		begin
			bp_rx_strobe_q <= line_rx_step;
			if (line_rx_step)
				bp_rx_bit_q <= sync_q[0];
		end
	end

	assign chk_src_bit = swap_q ? sync_q[2] : sync_q[0];
	assign chk_src_step = swap_q ? bp_tx_step : line_rx_step;
	assign chk_in = chk_src_bit ^ inv;
	assign chk_step = chk_en && chk_src_step;
	assign chk_err = chk_step && (chk_in != chk_pred);

	pattern_lfsr u_chk
	(
		.clk(clk),
		.rst_b(rst_b),
		.step(chk_step),
		.qrts(qrts),
		.self_sync(1'b1),
		.rx_bit(chk_in),
		.out_bit(chk_pred)
	);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			lock_q <= 1'b0;
			match_q <= '0;
			win_q <= '0;
			errs_q <= '0;
		end
		else if (!chk_en)
		begin
			lock_q <= 1'b0;
			match_q <= '0;
			win_q <= '0;
			errs_q <= '0;
		end
		else if (chk_step && !lock_q)
		begin
			if (chk_err)
				match_q <= '0;
			else if (match_q == CNT_W'(LOCK_MATCHES_P - 1))
			begin
				lock_q <= 1'b1;
				match_q <= '0;
				win_q <= '0;
				errs_q <= '0;
			end
			else
				match_q <= match_q + CNT_W'(1);
		end
		else if (chk_step)
		begin
			// Lock drops on too many errors inside one window
			if (chk_err && (errs_q == CNT_W'(LOSS_ERRORS_P - 1)))
			begin
				lock_q <= 1'b0;
				win_q <= '0;
				errs_q <= '0;
			end
			else if (win_q == CNT_W'(LOSS_WINDOW_P - 1))
			begin
				win_q <= '0;
				errs_q <= '0;
			end
			else
			begin
				win_q <= win_q + CNT_W'(1);
				errs_q <= errs_q + CNT_W'(chk_err);
			end
		end
	end

	// Interrupt events
	always_comb
	begin
		int_ev = '0;
		int_ev[INT_LOCK_GAINED] = chk_step && !lock_q && !chk_err
			&& (match_q == CNT_W'(LOCK_MATCHES_P - 1));
		int_ev[INT_LOCK_LOST] = chk_step && lock_q && chk_err
			&& (errs_q == CNT_W'(LOSS_ERRORS_P - 1));
		int_ev[INT_BIT_ERROR] = chk_err && lock_q;
	end

	assign rdata = rdata_q;
	assign irq = irq_q;
	assign line_tx_bit = line_tx_bit_q;
	assign line_tx_strobe = line_tx_strobe_q;
	assign bp_rx_bit = bp_rx_bit_q;
	assign bp_rx_strobe = bp_rx_strobe_q;
	assign rx_framer_skip = ctl_q[BIT_RX_FRAMER_SKIP];
	assign tx_framer_skip = ctl_q[BIT_TX_FRAMER_SKIP];

endmodule

//--- logic/pattern_lfsr.sv
// Shift register for the test pattern, used as generator or self-synchronising checker.
// Assumes step is a one-cycle pulse on the block clock.
`timescale 1ns/1ps
module pattern_lfsr
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control
	input wire logic step,
	input wire logic qrts,
	input wire logic self_sync,
	input wire logic rx_bit,
	// Pattern bit due at the next step
	output logic out_bit
);
	import bert_pkg::*;

	logic [LFSR_W-1:0] state_q;
	logic fb;
	logic suppress;

	always_comb
	begin
		if (qrts)
			fb = state_q[QRTS_LEN-1] ^ state_q[QRTS_TAP-1];
		else
			fb = state_q[PRBS15_LEN-1] ^ state_q[PRBS15_TAP-1];
		// Long zero runs are forced to one in the quasi-random signal
		suppress = qrts && (state_q[QRTS_ZERO_RUN-1:0] == '0);
		out_bit = fb | suppress;
	end

	// Checker loads the line so it aligns without a separate search
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			state_q <= '1;
		else if (step)
			state_q <= {state_q[LFSR_W-2:0], (self_sync && !suppress) ? rx_bit : fb};
	end

endmodule

//--- tb/bert_ctl_properties.sv
// Port-level checks for the pattern test control block.
// Assumes shadows of control, swap and enable see every write the block takes.
`timescale 1ns/1ps
module bert_ctl_properties
#(
	parameter int BIT_DIV_P = 4
)
(
	// Clock, reset, register port
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [bert_pkg::ADDR_W-1:0] addr,
	input wire logic [bert_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [bert_pkg::DATA_W-1:0] rdata,
	// Outputs watched
	input wire logic irq,
	input wire logic line_tx_strobe,
	input wire logic bp_rx_strobe,
	input wire logic rx_framer_skip,
	input wire logic tx_framer_skip
);
	import bert_pkg::*;
	logic [7:0] ctl_q;
	logic swap_q;
	logic [INT_W-1:0] ien_q;
	logic [7:0] run_q;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctl_q <= CTL_RESET;
			swap_q <= 1'b0;
			ien_q <= INT_RESET;
		end
		else if (wr)
		begin
			if (addr == OFS_PATTERN_TEST_CONTROL_STATUS)
				ctl_q <= wdata;
			if (addr == OFS_PATH_SWAP)
				swap_q <= wdata[BIT_PATH_SWAP];
			if (addr == OFS_INT_ENABLE)
				ien_q <= wdata[INT_W-1:0];
		end
	end
	// Settling time after any direction change, so the divider phase is known
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			run_q <= 8'h00;
		else if (wr && (addr == OFS_PATTERN_TEST_CONTROL_STATUS || addr == OFS_PATH_SWAP))
			run_q <= 8'h00;
		else if (run_q != 8'hff)
			run_q <= run_q + 8'h01;
	end
	wire gen_on = ctl_q[BIT_GENERATOR_ENABLE];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
		else $error("read data not zero outside read");
	tx_skip_a: assert property (tx_framer_skip == ctl_q[BIT_TX_FRAMER_SKIP])
		else $error("transmit bypass level wrong");
	rx_skip_a: assert property (rx_framer_skip == ctl_q[BIT_RX_FRAMER_SKIP])
		else $error("receive bypass level wrong");
	ctl_readback_a: assert property (
		rd && addr == OFS_PATTERN_TEST_CONTROL_STATUS |=> rdata[3:0] == $past(ctl_q[3:0]))
		else $error("control readback wrong");
	rsvd_read_a: assert property (
		rd && (addr == OFS_LOOP_CODE_CONTROL_RESERVED || addr == OFS_TX_LOOP_CODE_RESERVED)
		|=> rdata == 8'h00) else $error("reserved register not zero");
	chk_off_lock_a: assert property (
		rd && addr == OFS_PATTERN_TEST_CONTROL_STATUS && !ctl_q[BIT_CHECKER_ENABLE]
		|=> !rdata[BIT_CHECKER_LOCK_STATUS]) else $error("lock shown while checker off");
	gen_line_rate_a: assert property (
		gen_on && !swap_q && run_q > 8'h14 |-> line_tx_strobe == $past(line_tx_strobe, BIT_DIV_P))
		else $error("line pattern bit spacing wrong");
	gen_bp_rate_a: assert property (
		gen_on && swap_q && run_q > 8'h14 |-> bp_rx_strobe == $past(bp_rx_strobe, BIT_DIV_P))
		else $error("backplane pattern bit spacing wrong");
	irq_mask_a: assert property ((ien_q == INT_RESET)[*2] |-> !irq)
		else $error("interrupt while all sources masked");
	cover property (rd ##1 rdata[BIT_CHECKER_LOCK_STATUS]);
	cover property ($rose(irq));
	cover property (bp_rx_strobe && gen_on && swap_q);
endmodule

bind bert_ctl bert_ctl_properties #(.BIT_DIV_P(BIT_DIV_P)) props (.clk(clk), .rst_b(rst_b),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
	.line_tx_strobe(line_tx_strobe), .bp_rx_strobe(bp_rx_strobe),
	.rx_framer_skip(rx_framer_skip), .tx_framer_skip(tx_framer_skip));

//--- tb/loop_partner.sv
// Far-side model that loops a serial stream back, promptly or one cycle late.
// Assumes input bits are spaced at least four clocks apart.
`timescale 1ns/1ps
module loop_partner
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Stream in and control
	input wire logic in_bit,
	input wire logic in_strobe,
	input wire logic slow,
	// Stream back
	output logic out_bit,
	output logic out_strobe
);
	logic s1_q;
	logic b1_q;
	logic cnt_q;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s1_q <= 1'b0;
			b1_q <= 1'b0;
			cnt_q <= 1'b0;
			out_bit <= 1'b0;
			out_strobe <= 1'b0;
		end
		else
		begin
			s1_q <= in_strobe;
			b1_q <= in_bit;
			if (slow ? s1_q : in_strobe)
			begin
				out_bit <= slow ? b1_q : in_bit;
				out_strobe <= 1'b1;
				cnt_q <= 1'b1;
			end
			else if (cnt_q)
				cnt_q <= 1'b0;
			// Released data flips so a stale value never passes for fresh
			else if (out_strobe)
			begin
				out_strobe <= 1'b0;
				out_bit <= ~out_bit;
			end
		end
	end
endmodule

//--- tb/tb_e1_bert_control_bypass.sv
// Self-checking bench for the pattern test control block.
// Assumes looped-back far sides on line and backplane.
`timescale 1ns/1ps
module tb_e1_bert_control_bypass;
	import bert_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic slow = 1'b0;
	logic [7:0] rdata;
	logic irq;
	logic lrb, lrs, btb, bts, ltb, lts, brb, brs, rxs, txs;
	int num_errors = 0;
	int samples_checked = 0;
	logic [7:0] d;
	logic [7:0] v;
	int n_bad;
	logic [7:0] rsv [3] = '{8'h01, 8'h02, 8'h07};
	bert_ctl #(.BIT_DIV_P(4), .LOCK_MATCHES_P(8), .LOSS_WINDOW_P(16), .LOSS_ERRORS_P(2)) DUT (
		.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .irq(irq), .line_rx_bit(lrb), .line_rx_strobe(lrs),
		.bp_tx_bit(btb), .bp_tx_strobe(bts), .line_tx_bit(ltb), .line_tx_strobe(lts),
		.bp_rx_bit(brb), .bp_rx_strobe(brs), .rx_framer_skip(rxs), .tx_framer_skip(txs));
	loop_partner line_p (.clk(clk), .rst_b(rst_b), .in_bit(ltb), .in_strobe(lts),
		.slow(slow), .out_bit(lrb), .out_strobe(lrs));
	loop_partner bp_p (.clk(clk), .rst_b(rst_b), .in_bit(brb), .in_strobe(brs),
		.slow(slow), .out_bit(btb), .out_strobe(bts));
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	function automatic logic [7:0] exp_ctl(input logic [7:0] w, input logic lock);
		return (w & 8'hef) | {3'h0, lock, 4'h0};
	endfunction
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		addr <= a;
		wdata <= x;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] x);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 x = rdata;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic irq_step(input logic [7:0] a, input logic [7:0] x, input logic e);
		wr_reg(a, x);
		repeat (2) @(posedge clk);
		#1 chk({7'h0, irq}, {7'h0, e});
	endtask
	task automatic wait_lock(output logic [7:0] x);
		for (int n = 0; n < 100; n++)
		begin
			rd_reg(OFS_PATTERN_TEST_CONTROL_STATUS, x);
			if (x[BIT_CHECKER_LOCK_STATUS] === 1'b1)
				break;
		end
	endtask
	// Counts line bits that break the fifteen-stage recurrence
	task automatic line_recur(output int bad);
		logic [14:0] h;
		h = '0;
		bad = 0;
		for (int n = 0; n < 60; n++)
		begin
			@(posedge clk iff lts === 1'b1);
			if (n >= 15 && ltb !== (h[14] ^ h[13]))
				bad++;
			h = {h[13:0], ltb};
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		#200000;
		num_errors++;
		stop_test();
	end
	initial
	begin
		void'($urandom(56456));
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		rd_reg(OFS_PATTERN_TEST_CONTROL_STATUS, d);
		chk(d, CTL_RESET);
		chk({6'h0, rxs, txs}, 8'h00);
		foreach (rsv[k])
		begin
			wr_reg(rsv[k], 8'($urandom));
			rd_reg(rsv[k], d);
			chk(d, 8'h00);
		end
		rd_reg(OFS_PATTERN_TEST_CONTROL_STATUS, d);
		chk(d, CTL_RESET);
		$display("test 1 done");
		repeat (8)
		begin
			v = 8'($urandom) & 8'h13;
			wr_reg(OFS_PATTERN_TEST_CONTROL_STATUS, v);
			rd_reg(OFS_PATTERN_TEST_CONTROL_STATUS, d);
			chk(d, exp_ctl(v, 1'b0));
			chk({6'h0, rxs, txs}, {6'h0, v[1:0]});
		end
		$display("test 2 done");
		for (int i = 0; i < 4; i++)
		begin
			slow <= 1'($urandom);
			v = {i[1], 7'h0c};
			wr_reg(OFS_PATH_SWAP, {7'h0, i[0]});
			wr_reg(OFS_PATTERN_TEST_CONTROL_STATUS, v);
			wait_lock(d);
			chk(d, exp_ctl(v, 1'b1));
			// Swap off: only pattern type 0 may follow the fifteen-stage recurrence
			if (i[0] == 1'b0)
			begin
				line_recur(n_bad);
				chk({7'h0, n_bad != 0}, {7'h0, i[1]});
			end
			if (i == 0)
			begin
				irq_step(OFS_INT_ENABLE, 8'h01, 1'b1);
				irq_step(OFS_INT_ENABLE, 8'h00, 1'b0);
				irq_step(OFS_INT_ENABLE, 8'h01, 1'b1);
				irq_step(OFS_INT_CLEAR, 8'h01, 1'b0);
				irq_step(OFS_INT_ENABLE, 8'h00, 1'b0);
			end
			wr_reg(OFS_INT_CLEAR, 8'h07);
			// One inverted bit must surface as a bit error while locked
			wr_reg(OFS_PATTERN_TEST_CONTROL_STATUS, v | 8'h40);
			repeat (60) @(posedge clk);
			rd_reg(OFS_INT_STATUS, d);
			chk(d & 8'h04, 8'h04);
			wr_reg(OFS_PATTERN_TEST_CONTROL_STATUS, 8'h04);
			rd_reg(OFS_PATTERN_TEST_CONTROL_STATUS, d);
			chk(d, 8'h04);
			$display("test %0d done", i + 3);
		end
		stop_test();
	end
endmodule
